// [dv/mdfm_host_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Fault line as seen by the controller
// ----------------------------------------
module mdfm_host_model (
   input  wire logic fault_oe_i,
   output logic      fault_line_o
);
   // Pull-up unless the device sinks it
   assign fault_line_o = fault_oe_i ? 1'b0 : 1'b1;
endmodule : mdfm_host_model

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "mdfm_defines.svh"

module testbench;
   import mdfm_pkg::*;
   localparam int unsigned OCD = 3;
   localparam int unsigned RTY = 20;
   localparam logic [8:0]  HIZ = 9'b001101110;
   logic [11:0] flg [9] = '{12'h003, 12'h005, 12'h009, 12'h081, 12'h201, 12'h001, 12'h801, 12'h041, 12'h041};
   logic        clk, rst_n, cyc, stb, we, ph_oc, reg_oc, hall_run, sleep_n;
   logic        sup_uv, rail_uv, reg_uv, pump_uv, sup_ov, sclk_f, addr_f, otp_err, t_warn, die_hot, fet_hot;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat_w, dat_r, q;
   logic [2:0]  hall;
   logic        ack, hiz, pump_en, logic_en, flt_n, flt_oe, irq, flt_line;
   int          fails, check_count;

   mdfm_top #(.OC_DEG_CYC(OCD), .RETRY_CYC(RTY), .STALL_DET_CYC(30), .STALL_RETRY_CYC(25)) dut_u (
      .CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .SUPPLY_UV_I(sup_uv), .RAIL_UV_I(rail_uv),
      .REG_UV_I(reg_uv), .PUMP_UV_I(pump_uv), .SUPPLY_OV_I(sup_ov), .PHASE_OC_I(ph_oc), .REG_OC_I(reg_oc),
      .SCLK_FAULT_I(sclk_f), .ADDR_FAULT_I(addr_f), .OTP_ERR_I(otp_err), .HALL_I(hall), .THERM_WARN_I(t_warn),
      .DIE_HOT_I(die_hot), .FET_HOT_I(fet_hot), .SLEEP_N_I(sleep_n), .BRIDGE_HIZ_O(hiz), .PUMP_EN_O(pump_en),
      .LOGIC_EN_O(logic_en), .FAULT_OUT_N_O(flt_n), .FAULT_OE_O(flt_oe), .IRQ_O(irq));
   mdfm_host_model host_u (.fault_oe_i(flt_oe), .fault_line_o(flt_line));

   // ----------------------------------------
   // Clock and sensor activity
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (hall_run) hall <= hall + 3'h1;

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) fails++;
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd

   task automatic print_verdict;
      $display("comparisons=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict

   initial begin
      step(20000);
      fails++;
      print_verdict();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {cyc, stb, we, ph_oc, reg_oc, sup_uv, rail_uv, reg_uv, pump_uv, sup_ov} = '0;
      {sclk_f, addr_f, otp_err, t_warn, die_hot, fet_hot, rst_n, adr, dat_w, hall} = '0;
      {hall_run, sleep_n, sel} = 6'h3f;
      fails = 0;
      check_count = 0;
      step(5);
      rst_n <= 1'b1;
      step(1);
      rd(`MDFM_OFS_FLAGS, 32'h0);
      rd(8'h14, 32'h0);
      for (int i = 0; i < 2; i++) begin
         {rail_uv, sup_uv} <= 2'b01 << i;
         step(3);
         chk({pump_en, logic_en, hiz, flt_line}, 4'b0011);
         {rail_uv, sup_uv} <= 2'b00;
         step(3);
         chk({pump_en, logic_en, hiz}, 3'b110);
         rd(`MDFM_OFS_FLAGS, 32'h0);
         wb(1'b1, `MDFM_OFS_CTRL, 32'h80);
         rd(`MDFM_OFS_FLAGS, 32'h1);
      end
      wb(1'b1, `MDFM_OFS_IRQ_MASK, 32'h2);
      for (int i = 0; i < 9; i++) begin
         wb(1'b1, `MDFM_OFS_CTRL, 32'h41);
         {addr_f, sclk_f, fet_hot, die_hot, t_warn, otp_err, sup_ov, pump_uv, reg_uv} <= 9'h1 << i;
         step(4);
         chk({hiz, flt_line, flt_n}, {HIZ[i], 2'b00});
         {addr_f, sclk_f, fet_hot, die_hot, t_warn, otp_err, sup_ov, pump_uv, reg_uv} <= 9'h0;
         step(4);
         chk(flt_line, 32'(i != 3 && i < 7));
         rd(`MDFM_OFS_FLAGS, flg[i]);
         if (i == 3) sleep_n <= 1'b0;
         else wb(1'b1, `MDFM_OFS_CTRL, 32'hc1);
         step(3);
         sleep_n <= 1'b1;
         step(2);
         chk({hiz, flt_line}, 2'b01);
      end
      chk(irq, 32'h1);
      wb(1'b1, `MDFM_OFS_IRQ_STAT, 32'hfff);
      step(1);
      chk(irq, 32'h0);
      wb(1'b1, `MDFM_OFS_CTRL, 32'h20);
      {sclk_f, t_warn, sup_ov} <= 3'b111;
      step(4);
      chk({hiz, flt_line}, 2'b01);
      {sclk_f, t_warn, sup_ov} <= 3'b000;
      rd(`MDFM_OFS_FLAGS, 32'h1);
      ph_oc <= 1'b1;
      step(OCD - 1);
      ph_oc <= 1'b0;
      step(4);
      chk({hiz, flt_line}, 2'b01);
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, `MDFM_OFS_CTRL, 32'(m << 1));
         ph_oc <= 1'b1;
         step(OCD + 4);
         chk({hiz, flt_line}, {m < 2, m == 3});
         ph_oc <= 1'b0;
         step(RTY + 5);
         chk({hiz, flt_line}, {m == 0, m == 1 || m == 3});
         rd(`MDFM_OFS_FLAGS, (m == 3) ? 32'h1 : 32'h11);
         wb(1'b1, `MDFM_OFS_CTRL, 32'(m << 1) | 32'h80);
         step(3);
         chk({hiz, flt_line}, 2'b01);
      end
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, `MDFM_OFS_CTRL, 32'(m << 3));
         hall_run <= 1'b0;
         step(40);
         chk({hiz, flt_line}, {m < 2, m == 3});
         hall_run <= 1'b1;
         step(30);
         wb(1'b1, `MDFM_OFS_CTRL, 32'h80);
         step(3);
         chk({hiz, flt_line}, 2'b01);
      end
      reg_oc <= 1'b1;
      step(1);
      reg_oc <= 1'b0;
      step(3);
      chk({hiz, flt_line, flt_n}, 3'b000);
      rd(`MDFM_OFS_FLAGS, 32'h21);
      step(RTY + 3);
      chk({hiz, flt_line, flt_n}, 3'b011);
      print_verdict();
   end
endmodule : testbench

// [src/mdfm_chan.sv]
`timescale 1ns/1ps

module mdfm_chan
   import mdfm_pkg::*;
#(
   parameter int unsigned CW       = 32,
   parameter int unsigned DET      = 1,
   parameter int unsigned RETRY    = 1,
   parameter bit          CLR_IDLE = 1'b1
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       cond_i,
   input  wire logic       clear_i,
   input  wire mdfm_mode_t mode_i,
   output logic            event_o,
   output logic            flag_o,
   output logic            hiz_o,
   output logic            fault_o,
   output logic            retry_o
);

   localparam logic [CW-1:0] DET_M1 = CW'(DET - 1);
   localparam logic [CW-1:0] RTY_M1 = CW'(RETRY - 1);

   generate
      if (CW < 2 || CW > 32 || DET < 1 || RETRY < 1 || DET >= (64'd1 << CW) - 1) begin : g_bad
         $error("mdfm_chan: unusable counter width or count");
      end
   endgenerate

   logic [CW-1:0] det_cnt;
   logic [CW-1:0] next_det_cnt;
   logic [CW-1:0] rty_cnt;
   logic [CW-1:0] next_rty_cnt;
   mdfm_act_t     state;
   mdfm_act_t     next_state;
   logic          flag;
   logic          next_flag;

   // ----------------------------------------
   // Detection, action state, flag
   // ----------------------------------------
   always_comb begin
      next_det_cnt = det_cnt;
      next_rty_cnt = rty_cnt;
      next_state   = state;
      next_flag    = flag;
      if (!cond_i || state != ACT_IDLE) begin
         next_det_cnt = '0;
      end else if (det_cnt <= DET_M1) begin
         next_det_cnt = CW'(det_cnt + 1'b1);
      end
      event_o = ce_i && cond_i && state == ACT_IDLE && det_cnt == DET_M1;
      case (state)
         ACT_IDLE: begin
            if (event_o) begin
               case (mode_i)
                  MODE_LATCH:  next_state = ACT_LATCH;
                  MODE_RETRY: begin
                     next_state   = ACT_RETRY;
                     next_rty_cnt = '0;
                  end
                  MODE_REPORT: next_state = ACT_REPORT;
                  default:     next_state = ACT_IDLE;
               endcase
            end
         end
         ACT_LATCH, ACT_REPORT: begin
            if (clear_i && !(CLR_IDLE && cond_i)) begin
               next_state = ACT_IDLE;
            end
         end
         ACT_RETRY: begin
            if (rty_cnt == RTY_M1) begin
               next_state = ACT_IDLE;
            end else begin
               next_rty_cnt = CW'(rty_cnt + 1'b1);
            end
         end
         default: next_state = ACT_IDLE;
      endcase
      if (clear_i) begin
         next_flag = 1'b0;
      end
      if (event_o && mode_i != MODE_OFF) begin
         next_flag = 1'b1;
      end
      flag_o  = flag;
      hiz_o   = state == ACT_LATCH || state == ACT_RETRY;
      fault_o = state != ACT_IDLE;
      retry_o = state == ACT_RETRY;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         det_cnt <= '0;
         rty_cnt <= '0;
         state   <= ACT_IDLE;
         flag    <= 1'b0;
      end else if (ce_i) begin
         det_cnt <= next_det_cnt;
         rty_cnt <= next_rty_cnt;
         state   <= next_state;
         flag    <= next_flag;
      end
   end

endmodule : mdfm_chan

// [src/mdfm_defines.svh]
`ifndef MDFM_DEFINES_SVH
`define MDFM_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MDFM_OFS_CTRL      8'h00
`define MDFM_OFS_FLAGS     8'h04
`define MDFM_OFS_LIVE      8'h08
`define MDFM_OFS_IRQ_STAT  8'h0c
`define MDFM_OFS_IRQ_MASK  8'h10

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define MDFM_CTRL_W        7
`define MDFM_CTRL_CLR_BIT  7
`define MDFM_FLAGS_W       12
`define MDFM_LIVE_W        13
`define MDFM_CTRL_RST      7'h00
`define MDFM_FLAGS_RST     12'h000
`define MDFM_MASK_RST      12'h000

// ----------------------------------------
// Timing
// ----------------------------------------
`define MDFM_CLK_MHZ          100
`define MDFM_OC_DEG_NS        600
`define MDFM_OC_DEG_CYC       ((`MDFM_OC_DEG_NS * `MDFM_CLK_MHZ + 999) / 1000)
`define MDFM_RETRY_MS         5
`define MDFM_RETRY_CYC        (`MDFM_RETRY_MS * `MDFM_CLK_MHZ * 1000)
`define MDFM_STALL_DET_MS     1000
`define MDFM_STALL_DET_CYC    (`MDFM_STALL_DET_MS * `MDFM_CLK_MHZ * 1000)
`define MDFM_STALL_RETRY_MS   5000
`define MDFM_STALL_RETRY_CYC  (`MDFM_STALL_RETRY_MS * `MDFM_CLK_MHZ * 1000)
`define MDFM_REG_OC_DET_CYC   1

`endif

// [src/mdfm_pkg.sv]
package mdfm_pkg;

   typedef enum logic [1:0] {
      MODE_LATCH  = 2'b00,
      MODE_RETRY  = 2'b01,
      MODE_REPORT = 2'b10,
      MODE_OFF    = 2'b11
   } mdfm_mode_t;

   typedef enum logic [1:0] {
      ACT_IDLE   = 2'b00,
      ACT_LATCH  = 2'b01,
      ACT_RETRY  = 2'b10,
      ACT_REPORT = 2'b11
   } mdfm_act_t;

   typedef struct packed {
      logic       thermal_warn_report;
      logic       serial_error_report_disable;
      mdfm_mode_t stall_mode;
      mdfm_mode_t overcurrent_mode;
      logic       overvoltage_enable;
   } mdfm_ctrl_t;

   typedef struct packed {
      logic transistor_thermal_flag;
      logic die_thermal_shutdown;
      logic thermal_warn_flag;
      logic stall_flag;
      logic otp_error_flag;
      logic serial_error_flag;
      logic regulator_overcurrent_flag;
      logic overcurrent_flag;
      logic overvoltage_flag;
      logic pump_undervolt_flag;
      logic regulator_undervolt_flag;
      logic power_on_reset_flag;
   } mdfm_flags_t;

endpackage : mdfm_pkg

// [src/mdfm_top.sv]
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "mdfm_defines.svh"

// Behaviour
// - Supply lockout tristates bridge, stops pump and logic; resumes when supply returns.
// - After supply or rail lockout the power-on flag stays low until cleared.
// - Analog rail undervoltage disables bridge, pump and logic; resumes automatically.
// - Regulator undervoltage asserts fault only; flag held until clear.
// - Pump undervoltage asserts fault and tristates bridge; flag held until clear.
// - Overvoltage acts only when enabled: fault, tristate, flag held until clear.
// - Overcurrent mode selects latch, retry, report-only or no action.
// - Stall mode selects latch, retry, report-only or no action.
// - Clock-count or address errors flag and fault unless reporting is disabled.
// - Configuration read error faults and tristates until reset or sleep pulse.
// - Thermal warning faults only when reporting enabled; flag held until clear.
// - Over-temperature faults and tristates; transistor flag held until clear.
// - Overcurrent counts only after the current stays high for the deglitch time.
// - Stall is declared when hall inputs stay still for the detect time.
module mdfm_top
   import mdfm_pkg::*;
#(
   parameter int unsigned OC_DEG_CYC      = `MDFM_OC_DEG_CYC,
   parameter int unsigned RETRY_CYC       = `MDFM_RETRY_CYC,
   parameter int unsigned STALL_DET_CYC   = `MDFM_STALL_DET_CYC,
   parameter int unsigned STALL_RETRY_CYC = `MDFM_STALL_RETRY_CYC
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        CE_I,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [7:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   input  wire logic        SUPPLY_UV_I,
   input  wire logic        RAIL_UV_I,
   input  wire logic        REG_UV_I,
   input  wire logic        PUMP_UV_I,
   input  wire logic        SUPPLY_OV_I,
   input  wire logic        PHASE_OC_I,
   input  wire logic        REG_OC_I,
   input  wire logic        SCLK_FAULT_I,
   input  wire logic        ADDR_FAULT_I,
   input  wire logic        OTP_ERR_I,
   input  wire logic [2:0]  HALL_I,
   input  wire logic        THERM_WARN_I,
   input  wire logic        DIE_HOT_I,
   input  wire logic        FET_HOT_I,
   input  wire logic        SLEEP_N_I,
   output logic             BRIDGE_HIZ_O,
   output logic             PUMP_EN_O,
   output logic             LOGIC_EN_O,
   output logic             FAULT_OUT_N_O,
   output logic             FAULT_OE_O,
   output logic             IRQ_O
);

   generate
      if (OC_DEG_CYC < 1 || RETRY_CYC < 1 || STALL_DET_CYC < 1 || STALL_RETRY_CYC < 1) begin : g_bad
         $error("mdfm_top: every count must be at least one cycle");
      end
   endgenerate

   localparam int FW = `MDFM_FLAGS_W;

   mdfm_ctrl_t  ctrl;
   mdfm_ctrl_t  next_ctrl;
   logic        clr_cmd;
   logic        next_clr_cmd;
   mdfm_flags_t flags;
   mdfm_flags_t next_flags;
   logic [FW-1:0] irq_stat;
   logic [FW-1:0] next_irq_stat;
   logic [FW-1:0] irq_mask;
   logic [FW-1:0] next_irq_mask;
   logic [FW-1:0] ev;
   logic [2:0]  hall_q;
   logic        ack;
   logic        next_ack;
   logic [31:0] dat;
   logic [31:0] next_dat;
   logic        hiz;
   logic        next_hiz;
   logic        run;
   logic        next_run;
   logic        fault;
   logic        next_fault;
   logic        irq;
   logic        next_irq;
   logic        wb_req;
   logic        wr;
   logic [15:0] m16;
   logic        clear;
   logic        uv_now;
   logic        ov_act;
   logic        tw_act;
   logic        ser_ev;
   logic        hall_edge;
   logic        oc_ev, oc_flag, oc_hiz, oc_fault;
   logic        st_ev, st_flag, st_hiz, st_fault;
   logic        ro_fault, ro_retry;

   function automatic logic hold_f(input logic set, input logic cur, input logic clr);
      return set | (cur & ~clr);
   endfunction : hold_f

   // ----------------------------------------
   // Condition decode
   // ----------------------------------------
   always_comb begin
      wb_req    = CYC_I & STB_I & ~ack;
      wr        = wb_req & WE_I;
      m16       = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};
      clear     = clr_cmd | ~SLEEP_N_I;
      uv_now    = SUPPLY_UV_I | RAIL_UV_I;
      ov_act    = ctrl.overvoltage_enable & SUPPLY_OV_I;
      tw_act    = ctrl.thermal_warn_report & THERM_WARN_I;
      ser_ev    = (SCLK_FAULT_I | ADDR_FAULT_I) & ~ctrl.serial_error_report_disable;
      hall_edge = HALL_I != hall_q;
   end

   // ----------------------------------------
   // Protection channels: overcurrent and stall mode-driven, regulator overcurrent fixed to retry
   // ----------------------------------------
   mdfm_chan #(.CW(32), .DET(OC_DEG_CYC), .RETRY(RETRY_CYC), .CLR_IDLE(1'b1)) u_oc (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .ce_i    (CE_I),
      .cond_i  (PHASE_OC_I),
      .clear_i (clear),
      .mode_i  (ctrl.overcurrent_mode),
      .event_o (oc_ev),
      .flag_o  (oc_flag),
      .hiz_o   (oc_hiz),
      .fault_o (oc_fault),
      .retry_o ()
   );

   mdfm_chan #(.CW(32), .DET(STALL_DET_CYC), .RETRY(STALL_RETRY_CYC), .CLR_IDLE(1'b0)) u_stall (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .ce_i    (CE_I),
      .cond_i  (~hall_edge),
      .clear_i (clear),
      .mode_i  (ctrl.stall_mode),
      .event_o (st_ev),
      .flag_o  (st_flag),
      .hiz_o   (st_hiz),
      .fault_o (st_fault),
      .retry_o ()
   );

   mdfm_chan #(.CW(32), .DET(`MDFM_REG_OC_DET_CYC), .RETRY(RETRY_CYC), .CLR_IDLE(1'b0)) u_regoc (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .ce_i    (CE_I),
      .cond_i  (REG_OC_I),
      .clear_i (1'b0),
      .mode_i  (MODE_RETRY),
      .event_o (),
      .flag_o  (),
      .hiz_o   (),
      .fault_o (ro_fault),
      .retry_o (ro_retry)
   );

   // ----------------------------------------
   // Status flags and pin responses
   // ----------------------------------------
   always_comb begin
      next_flags = flags;
      next_flags.power_on_reset_flag        = uv_now ? 1'b0 : (clear | flags.power_on_reset_flag);
      next_flags.regulator_undervolt_flag   = hold_f(REG_UV_I, flags.regulator_undervolt_flag, clear);
      next_flags.pump_undervolt_flag        = hold_f(PUMP_UV_I, flags.pump_undervolt_flag, clear);
      next_flags.overvoltage_flag           = hold_f(ov_act, flags.overvoltage_flag, clear);
      next_flags.overcurrent_flag           = oc_flag;
      next_flags.regulator_overcurrent_flag = ro_retry;
      next_flags.serial_error_flag          = hold_f(ser_ev, flags.serial_error_flag, clear);
      next_flags.otp_error_flag             = hold_f(OTP_ERR_I, flags.otp_error_flag, ~SLEEP_N_I);
      next_flags.stall_flag                 = st_flag;
      next_flags.thermal_warn_flag          = hold_f(tw_act, flags.thermal_warn_flag, clear);
      next_flags.die_thermal_shutdown       = DIE_HOT_I;
      next_flags.transistor_thermal_flag    = hold_f(FET_HOT_I, flags.transistor_thermal_flag, clear);
      ev    = next_flags & ~flags;
      ev[0] = flags.power_on_reset_flag & ~next_flags.power_on_reset_flag;
      next_run   = ~uv_now;
      next_hiz   = uv_now | PUMP_UV_I | ov_act | oc_hiz | st_hiz
                 | flags.otp_error_flag | OTP_ERR_I | DIE_HOT_I | FET_HOT_I;
      next_fault = REG_UV_I | PUMP_UV_I | ov_act | oc_fault | st_fault | ro_fault
                 | flags.serial_error_flag | ser_ev | flags.otp_error_flag | OTP_ERR_I
                 | tw_act | DIE_HOT_I | FET_HOT_I;
   end

   // ----------------------------------------
   // Bus slave and interrupt
   // ----------------------------------------
   always_comb begin
      next_ctrl     = ctrl;
      next_clr_cmd  = 1'b0;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat | ev;
      next_ack      = wb_req;
      next_dat      = 32'h0000_0000;
      if (wr && ADR_I == `MDFM_OFS_CTRL && SEL_I[0]) begin
         next_ctrl    = mdfm_ctrl_t'(DAT_I[`MDFM_CTRL_W-1:0]);
         next_clr_cmd = DAT_I[`MDFM_CTRL_CLR_BIT];
      end
      if (wr && ADR_I == `MDFM_OFS_IRQ_MASK) begin
         next_irq_mask = (irq_mask & ~m16[FW-1:0]) | (DAT_I[FW-1:0] & m16[FW-1:0]);
      end
      if (wr && ADR_I == `MDFM_OFS_IRQ_STAT) begin
         next_irq_stat = (irq_stat & ~(DAT_I[FW-1:0] & m16[FW-1:0])) | ev;
      end
      if (wb_req && !WE_I) begin
         case (ADR_I)
            `MDFM_OFS_CTRL:     next_dat = {25'h0, ctrl};
            `MDFM_OFS_FLAGS:    next_dat = {20'h0, flags};
            `MDFM_OFS_LIVE:     next_dat = {19'h0, hiz, fault, FET_HOT_I, DIE_HOT_I, THERM_WARN_I,
                                            OTP_ERR_I, REG_OC_I, PHASE_OC_I, SUPPLY_OV_I, PUMP_UV_I,
                                            REG_UV_I, RAIL_UV_I, SUPPLY_UV_I};
            `MDFM_OFS_IRQ_STAT: next_dat = {20'h0, irq_stat};
            `MDFM_OFS_IRQ_MASK: next_dat = {20'h0, irq_mask};
            default:            next_dat = 32'h0000_0000;
         endcase
      end
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ctrl     <= mdfm_ctrl_t'(`MDFM_CTRL_RST);
         clr_cmd  <= 1'b0;
         flags    <= mdfm_flags_t'(`MDFM_FLAGS_RST);
         irq_stat <= `MDFM_FLAGS_RST;
         irq_mask <= `MDFM_MASK_RST;
         hall_q   <= 3'h0;
         ack      <= 1'b0;
         dat      <= 32'h0000_0000;
         hiz      <= 1'b1;
         run      <= 1'b0;
         fault    <= 1'b0;
         irq      <= 1'b0;
      end else if (CE_I) begin
         ctrl     <= next_ctrl;
         clr_cmd  <= next_clr_cmd;
         flags    <= next_flags;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         hall_q   <= HALL_I;
         ack      <= next_ack;
         dat      <= next_dat;
         hiz      <= next_hiz;
         run      <= next_run;
         fault    <= next_fault;
         irq      <= next_irq;
      end
   end

   assign DAT_O         = dat;
   assign ACK_O         = ack;
   assign BRIDGE_HIZ_O  = hiz;
   assign PUMP_EN_O     = run;
   assign LOGIC_EN_O    = run;
   assign FAULT_OUT_N_O = ~fault;
   assign FAULT_OE_O    = fault;
   assign IRQ_O         = irq;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_uv;
      CE_I && uv_now;
   endsequence
   sequence s_oc_latch;
      CE_I && oc_ev && ctrl.overcurrent_mode == MODE_LATCH ##1 CE_I;
   endsequence
   sequence s_st_retry;
      CE_I && st_ev && ctrl.stall_mode == MODE_RETRY ##1 CE_I;
   endsequence

   property p_supply_lock;
      CE_I && SUPPLY_UV_I |=> BRIDGE_HIZ_O && !PUMP_EN_O && !LOGIC_EN_O;
   endproperty
   a_supply_lock: assert property (p_supply_lock) else $error("supply lockout not applied");
   property p_por_low;
      s_uv |=> !flags.power_on_reset_flag;
   endproperty
   a_por_low: assert property (p_por_low) else $error("power-on flag not held low");
   property p_rail_lock;
      CE_I && RAIL_UV_I |=> BRIDGE_HIZ_O && !LOGIC_EN_O;
   endproperty
   a_rail_lock: assert property (p_rail_lock) else $error("rail lockout not applied");
   property p_reg_uv;
      CE_I && REG_UV_I |=> FAULT_OE_O && flags.regulator_undervolt_flag;
   endproperty
   a_reg_uv: assert property (p_reg_uv) else $error("regulator undervoltage not reported");
   property p_pump_uv;
      CE_I && PUMP_UV_I |=> BRIDGE_HIZ_O && FAULT_OE_O && flags.pump_undervolt_flag;
   endproperty
   a_pump_uv: assert property (p_pump_uv) else $error("pump undervoltage not handled");
   property p_ov;
      CE_I && SUPPLY_OV_I && ctrl.overvoltage_enable |=> BRIDGE_HIZ_O && flags.overvoltage_flag;
   endproperty
   a_ov: assert property (p_ov) else $error("overvoltage not handled");
   property p_oc_latch;
      s_oc_latch |=> BRIDGE_HIZ_O && !FAULT_OUT_N_O;
   endproperty
   a_oc_latch: assert property (p_oc_latch) else $error("overcurrent latch missing");
   property p_st_retry;
      s_st_retry |=> BRIDGE_HIZ_O && FAULT_OE_O;
   endproperty
   a_st_retry: assert property (p_st_retry) else $error("stall retry shutdown missing");
   property p_ser;
      CE_I && SCLK_FAULT_I && !ctrl.serial_error_report_disable |=> flags.serial_error_flag && FAULT_OE_O;
   endproperty
   a_ser: assert property (p_ser) else $error("serial error not reported");
   property p_otp_keep;
      CE_I && flags.otp_error_flag && SLEEP_N_I |=> flags.otp_error_flag && BRIDGE_HIZ_O;
   endproperty
   a_otp_keep: assert property (p_otp_keep) else $error("configuration error latch lost");
   property p_tw;
      CE_I && THERM_WARN_I && ctrl.thermal_warn_report |=> FAULT_OE_O && flags.thermal_warn_flag;
   endproperty
   a_tw: assert property (p_tw) else $error("thermal warning not reported");
   property p_fet_hot;
      CE_I && FET_HOT_I |=> BRIDGE_HIZ_O && FAULT_OE_O && flags.transistor_thermal_flag;
   endproperty
   a_fet_hot: assert property (p_fet_hot) else $error("transistor shutdown not applied");
   property p_oc_cond;
      oc_ev |-> PHASE_OC_I;
   endproperty
   a_oc_cond: assert property (p_oc_cond) else $error("overcurrent event without current");
   property p_st_cond;
      st_ev |-> HALL_I == hall_q;
   endproperty
   a_st_cond: assert property (p_st_cond) else $error("stall event despite hall edge");
   property p_fault_pin;
      FAULT_OE_O == !FAULT_OUT_N_O;
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("fault pin enable mismatch");

endmodule : mdfm_top
